// File: intack_pkg.sv
package intack_pkg;

   // ************************************************************
   // Bus widths
   // ************************************************************
   localparam int BYTE_W      = 8;
   localparam int CPU_DATA_W  = 64;
   localparam int CPU_ADDR_W  = 32;
   localparam int PCI_AD_W    = 32;
   localparam int CBE_W       = 4;
   localparam int TSIZ_W      = 3;
   localparam int LANE_W      = 3;
   localparam int LANE_COUNT  = 8;

   // ************************************************************
   // Decode values
   // ************************************************************
   localparam logic [CPU_ADDR_W-1:0] INTACK_ADDR     = 32'hbfff_fff0;
   localparam logic [TSIZ_W-1:0]     TSIZ_ONE_BYTE   = 3'h1;
   localparam logic [CBE_W-1:0]      PCI_CMD_INTACK  = 4'h0;
   localparam logic [CBE_W-1:0]      CBE_LANE0_ONLY  = 4'he;
   localparam logic [CBE_W-1:0]      CBE_IDLE        = 4'hf;
   localparam logic [PCI_AD_W-1:0]   AD_PULLED_UP    = 32'hffff_ffff;

   // ************************************************************
   // Exception vector locations
   // ************************************************************
   localparam logic [CPU_ADDR_W-1:0] VECTOR_LOC_LOW  = 32'h0000_0500;
   localparam logic [CPU_ADDR_W-1:0] VECTOR_LOC_HIGH = 32'hfff0_0500;

   // ************************************************************
   // Timing and fill values
   // ************************************************************
   localparam logic [2:0]            DEVSEL_TIMEOUT  = 3'h5;
   localparam logic [2:0]            COUNT_ONE       = 3'h1;
   localparam logic [BYTE_W-1:0]     ABORT_VECTOR    = 8'hff;
   localparam logic [CPU_DATA_W-1:0] CPU_DATA_ZERO   = 64'h0;

endpackage

// File: intack_if.sv
`timescale 1ns/10ps
interface intack_if;
   import intack_pkg::*;

   // ************************************************************
   // Interrupt lines
   // ************************************************************
   logic                  int_req;
   logic                  nmi_req;
   logic                  int_cpu_n;

   // ************************************************************
   // CPU bus
   // ************************************************************
   logic                  ts_n;
   logic                  cpu_rd;
   logic [CPU_ADDR_W-1:0] cpu_addr;
   logic [TSIZ_W-1:0]     cpu_tsiz;
   logic [CPU_DATA_W-1:0] cpu_data;
   logic                  transfer_ack_n;

   // ************************************************************
   // PCI bus
   // ************************************************************
   logic                  req_n;
   logic                  gnt_n;
   logic                  frame_n;
   logic                  irdy_n;
   logic                  trdy_n;
   logic                  devsel_n;
   logic [CBE_W-1:0]      cbe_n;
   logic [PCI_AD_W-1:0]   ad_brg;
   logic                  ad_brg_oe;
   logic [PCI_AD_W-1:0]   ad_ctl;
   logic                  ad_ctl_oe;
   logic [PCI_AD_W-1:0]   ad;

   // The shared lines float high when no agent drives them.
   assign ad = ad_brg_oe ? ad_brg : (ad_ctl_oe ? ad_ctl : AD_PULLED_UP);

   modport bridge (
      input  int_req, nmi_req, ts_n, cpu_rd, cpu_addr, cpu_tsiz,
      input  gnt_n, trdy_n, devsel_n, ad,
      output int_cpu_n, cpu_data, transfer_ack_n,
      output req_n, frame_n, irdy_n, cbe_n, ad_brg, ad_brg_oe
   );

   modport partner (
      input  int_cpu_n, cpu_data, transfer_ack_n,
      input  req_n, frame_n, irdy_n, cbe_n, ad,
      output int_req, nmi_req, ts_n, cpu_rd, cpu_addr, cpu_tsiz,
      output gnt_n, trdy_n, devsel_n, ad_ctl, ad_ctl_oe
   );

endinterface

// File: intack_partner.sv
`timescale 1ns/10ps
module intack_partner
   import intack_pkg::*;
(
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_reset_n,
   // Link
   intack_if.partner              link,
   // CPU side control
   input  wire logic              i_enable_set,
   input  wire logic              i_exc_prefix,
   // Interrupt controller side
   input  wire logic              i_irq,
   input  wire logic [BYTE_W-1:0] i_vector,
   input  wire logic              i_error_src,
   // Status
   output logic                   o_enable_bit,
   output logic [CPU_ADDR_W-1:0]  o_branch_addr,
   output logic                   o_int_taken,
   output logic [BYTE_W-1:0]      o_vector,
   output logic                   o_vector_valid
);

   typedef enum logic [1:0] {CPU_IDLE, CPU_TS, CPU_WAIT} cpu_state_t;
   typedef enum logic {CTL_IDLE, CTL_DATA} ctl_state_t;

   typedef struct packed {
      cpu_state_t            cpu;
      ctl_state_t            ctl;
      logic [2:0]            int_sync;
      logic                  cpu_interrupt_enable_bit;
      logic [CPU_ADDR_W-1:0] branch_addr;
      logic                  int_taken;
      logic [BYTE_W-1:0]     vector;
      logic                  vector_valid;
      logic                  ts_n;
      logic                  pending;
      logic                  nmi_req;
      logic                  gnt_n;
      logic                  trdy_n;
      logic                  devsel_n;
      logic [PCI_AD_W-1:0]   ad_ctl;
      logic                  ad_ctl_oe;
   } partner_state_t;

   partner_state_t st;
   partner_state_t next_st;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_st              = st;
      next_st.int_sync     = {st.int_sync[1:0], link.int_cpu_n};
      next_st.int_taken    = 1'b0;
      next_st.vector_valid = 1'b0;
      next_st.gnt_n        = link.req_n;
      next_st.nmi_req      = i_error_src;
      if (i_irq) begin
         next_st.pending = 1'b1;
      end
      if (i_enable_set) begin
         next_st.cpu_interrupt_enable_bit = 1'b1;
      end
      case (st.cpu)
         CPU_IDLE: begin
            // Both late stages must agree before the request counts.
            if (!st.int_sync[1] && !st.int_sync[2] && st.cpu_interrupt_enable_bit) begin
               next_st.cpu_interrupt_enable_bit = 1'b0;
               next_st.branch_addr = i_exc_prefix ? VECTOR_LOC_HIGH : VECTOR_LOC_LOW;
               next_st.int_taken   = 1'b1;
               next_st.ts_n        = 1'b0;
               next_st.cpu         = CPU_TS;
            end
         end
         CPU_TS: begin
            next_st.ts_n = 1'b1;
            next_st.cpu  = CPU_WAIT;
         end
         default: begin
            if (!link.transfer_ack_n) begin
               next_st.vector       = link.cpu_data[CPU_DATA_W-1 -: BYTE_W];
               next_st.vector_valid = 1'b1;
               next_st.cpu          = CPU_IDLE;
            end
         end
      endcase
      case (st.ctl)
         CTL_IDLE: begin
            if (!link.frame_n && (link.cbe_n == PCI_CMD_INTACK)) begin
               next_st.devsel_n  = 1'b0;
               next_st.trdy_n    = 1'b0;
               next_st.ad_ctl    = {{(PCI_AD_W-BYTE_W){1'b0}}, i_vector};
               next_st.ad_ctl_oe = 1'b1;
               next_st.ctl       = CTL_DATA;
            end
         end
         default: begin
            if (!link.irdy_n) begin
               next_st.devsel_n  = 1'b1;
               next_st.trdy_n    = 1'b1;
               next_st.ad_ctl_oe = 1'b0;
               next_st.pending   = i_irq;
               next_st.ctl       = CTL_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         st          <= '0;
         st.cpu      <= CPU_IDLE;
         st.ctl      <= CTL_IDLE;
         st.int_sync <= 3'h7;
         st.ts_n     <= 1'b1;
         st.gnt_n    <= 1'b1;
         st.trdy_n   <= 1'b1;
         st.devsel_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign link.int_req   = st.pending;
   assign link.nmi_req   = st.nmi_req;
   assign link.ts_n      = st.ts_n;
   assign link.cpu_rd    = 1'b1;
   assign link.cpu_addr  = INTACK_ADDR;
   assign link.cpu_tsiz  = TSIZ_ONE_BYTE;
   assign link.gnt_n     = st.gnt_n;
   assign link.trdy_n    = st.trdy_n;
   assign link.devsel_n  = st.devsel_n;
   assign link.ad_ctl    = st.ad_ctl;
   assign link.ad_ctl_oe = st.ad_ctl_oe;
   assign o_enable_bit   = st.cpu_interrupt_enable_bit;
   assign o_branch_addr  = st.branch_addr;
   assign o_int_taken    = st.int_taken;
   assign o_vector       = st.vector;
   assign o_vector_valid = st.vector_valid;

endmodule

// File: intack_bridge.sv
`timescale 1ns/10ps

module intack_bridge
   import intack_pkg::*;
(
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_reset_n,
   // Link
   intack_if.bridge               link,
   // Mode and error control
   input  wire logic              i_legacy_err_mode,
   input  wire logic              i_err_clear,
   // Status
   output logic                   o_err_flag,
   output logic                   o_intack_busy,
   output logic                   o_master_abort
);

   typedef enum logic [2:0] {
      BR_IDLE,
      BR_ARB,
      BR_ADDR,
      BR_DATA,
      BR_ACK
   } bridge_state_t;

   typedef struct packed {
      bridge_state_t         state;
      logic [LANE_W-1:0]     lane;
      logic [2:0]            wait_cnt;
      logic [2:0]            nmi_sync;
      logic                  err_flag;
      logic                  master_abort;
      logic                  busy;
      logic                  int_cpu_n;
      logic                  transfer_ack_n;
      logic [CPU_DATA_W-1:0] cpu_data;
      logic                  req_n;
      logic                  frame_n;
      logic                  irdy_n;
      logic [CBE_W-1:0]      cbe_n;
      logic [PCI_AD_W-1:0]   ad_brg;
      logic                  ad_brg_oe;
   } bridge_reg_t;

   bridge_reg_t st;
   bridge_reg_t next_st;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic is_intack_read(
      input logic                  ts_n,
      input logic                  rd,
      input logic [CPU_ADDR_W-1:0] addr,
      input logic [TSIZ_W-1:0]     tsiz
   );
      is_intack_read = !ts_n && rd && (addr == INTACK_ADDR) && (tsiz == TSIZ_ONE_BYTE);
   endfunction

   // Byte lane 0 of the CPU bus is the most significant byte.
   function automatic logic [CPU_DATA_W-1:0] place_on_lane(
      input logic [BYTE_W-1:0] value,
      input logic [LANE_W-1:0] lane
   );
      logic [CPU_DATA_W-1:0] word;
      word = CPU_DATA_ZERO;
      for (int i = 0; i < LANE_COUNT; i++) begin
         if (lane == i[LANE_W-1:0]) begin
            word[CPU_DATA_W-1-BYTE_W*i -: BYTE_W] = value;
         end
      end
      place_on_lane = word;
   endfunction

   // ************************************************************
   // Error and interrupt path
   // ************************************************************
   logic nmi_seen;
   logic err_raise;

   always_comb begin
      // Only the two later stages are compared; the first may be metastable.
      nmi_seen  = st.nmi_sync[1] && st.nmi_sync[2];
      err_raise = nmi_seen;
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_st          = st;
      next_st.nmi_sync = {st.nmi_sync[1:0], link.nmi_req};

      // A new error in the cycle of a clear still sets the flag.
      if (err_raise) begin
         next_st.err_flag = 1'b1;
      end else if (i_err_clear) begin
         next_st.err_flag = 1'b0;
      end

      // The interrupt request is only registered, never synchronised: the CPU samples
      // it asynchronously, and a synchroniser would only add latency here.
      next_st.int_cpu_n = !(link.int_req || (i_legacy_err_mode && st.err_flag));

      case (st.state)
         BR_IDLE: begin
            next_st.master_abort = 1'b0;
            if (is_intack_read(link.ts_n, link.cpu_rd, link.cpu_addr, link.cpu_tsiz)) begin
               next_st.lane  = link.cpu_addr[LANE_W-1:0];
               next_st.req_n = 1'b0;
               next_st.state = BR_ARB;
            end
         end
         BR_ARB: begin
            if (!link.gnt_n) begin
               next_st.req_n     = 1'b1;
               next_st.frame_n   = 1'b0;
               next_st.ad_brg    = INTACK_ADDR;
               next_st.ad_brg_oe = 1'b1;
               next_st.cbe_n     = PCI_CMD_INTACK;
               next_st.state     = BR_ADDR;
            end
         end
         BR_ADDR: begin
            next_st.frame_n   = 1'b1;
            next_st.irdy_n    = 1'b0;
            next_st.ad_brg_oe = 1'b0;
            next_st.cbe_n     = CBE_LANE0_ONLY;
            next_st.wait_cnt  = '0;
            next_st.state     = BR_DATA;
         end
         BR_DATA: begin
            if (!link.trdy_n && !link.devsel_n) begin
               next_st.irdy_n         = 1'b1;
               next_st.cbe_n          = CBE_IDLE;
               next_st.cpu_data       = place_on_lane(link.ad[BYTE_W-1:0], st.lane);
               next_st.transfer_ack_n = 1'b0;
               next_st.state          = BR_ACK;
            end else if (link.devsel_n && (st.wait_cnt == DEVSEL_TIMEOUT)) begin
               // Nobody claimed the cycle: end it and hand the CPU an all-ones byte
               // rather than hang the processor forever.
               next_st.irdy_n         = 1'b1;
               next_st.cbe_n          = CBE_IDLE;
               next_st.cpu_data       = place_on_lane(ABORT_VECTOR, st.lane);
               next_st.transfer_ack_n = 1'b0;
               next_st.master_abort   = 1'b1;
               next_st.state          = BR_ACK;
            end else begin
               next_st.wait_cnt = st.wait_cnt + COUNT_ONE;
            end
         end
         BR_ACK: begin
            next_st.transfer_ack_n = 1'b1;
            next_st.cpu_data       = CPU_DATA_ZERO;
            next_st.state          = BR_IDLE;
         end
         default: begin
            next_st.state = BR_IDLE;
         end
      endcase

      // The busy flag is registered so that the status pin comes straight from a flop.
      next_st.busy = (next_st.state != BR_IDLE);
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         st                <= '0;
         st.state          <= BR_IDLE;
         st.int_cpu_n      <= 1'b1;
         st.transfer_ack_n <= 1'b1;
         st.req_n          <= 1'b1;
         st.frame_n        <= 1'b1;
         st.irdy_n         <= 1'b1;
         st.cbe_n          <= CBE_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign link.int_cpu_n      = st.int_cpu_n;
   assign link.transfer_ack_n = st.transfer_ack_n;
   assign link.cpu_data       = st.cpu_data;
   assign link.req_n          = st.req_n;
   assign link.frame_n        = st.frame_n;
   assign link.irdy_n         = st.irdy_n;
   assign link.cbe_n          = st.cbe_n;
   assign link.ad_brg         = st.ad_brg;
   assign link.ad_brg_oe      = st.ad_brg_oe;
   assign o_err_flag          = st.err_flag;
   assign o_intack_busy       = st.busy;
   assign o_master_abort      = st.master_abort;

endmodule

// File: intack_properties.sv
`timescale 1ns/10ps
module intack_properties
   import intack_pkg::*;
(
   // Clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_reset_n,
   // Interface lines
   input  wire logic                  int_req,
   input  wire logic                  nmi_req,
   input  wire logic                  int_cpu_n,
   input  wire logic                  ts_n,
   input  wire logic                  cpu_rd,
   input  wire logic [CPU_ADDR_W-1:0] cpu_addr,
   input  wire logic [TSIZ_W-1:0]     cpu_tsiz,
   input  wire logic [CPU_DATA_W-1:0] cpu_data,
   input  wire logic                  transfer_ack_n,
   input  wire logic                  req_n,
   input  wire logic                  frame_n,
   input  wire logic                  irdy_n,
   input  wire logic [CBE_W-1:0]      cbe_n,
   input  wire logic [PCI_AD_W-1:0]   ad
);
   // ************************************************************
   // Helper logic
   // ************************************************************
   // The lane 0 byte is kept one cycle so that it can be matched against the CPU read data.
   logic [BYTE_W-1:0] ad_low;

   always_ff @(posedge i_core_clk) begin
      ad_low <= ad[BYTE_W-1:0];
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   // ************************************************************
   // Properties
   // ************************************************************
   property p_inv_follow;
      int_req |=> !int_cpu_n;
   endproperty
   a_inv_follow: assert property (p_inv_follow) else $error("CPU interrupt not asserted after request.");

   property p_nmi_isolated;
      $rose(nmi_req) && !int_req |=> int_cpu_n;
   endproperty
   a_nmi_isolated: assert property (p_nmi_isolated) else $error("Non-maskable request reached CPU interrupt.");

   property p_ack_request;
      !ts_n && cpu_rd && cpu_addr == INTACK_ADDR && cpu_tsiz == TSIZ_ONE_BYTE |=> !req_n;
   endproperty
   a_ack_request: assert property (p_ack_request) else $error("No bus request after acknowledge read.");

   property p_ack_command;
      $fell(frame_n) |-> cbe_n == PCI_CMD_INTACK && ad == INTACK_ADDR;
   endproperty
   a_ack_command: assert property (p_ack_command) else $error("Wrong command or address phase.");

   property p_lane0_only;
      !irdy_n |-> cbe_n == CBE_LANE0_ONLY;
   endproperty
   a_lane0_only: assert property (p_lane0_only) else $error("Byte enables other than lane zero.");

   property p_wait_states;
      !ts_n |-> transfer_ack_n [*4];
   endproperty
   a_wait_states: assert property (p_wait_states) else $error("Transfer acknowledge came too early.");

   property p_vector_lane;
      !transfer_ack_n |-> cpu_data == {ad_low, 56'h0};
   endproperty
   a_vector_lane: assert property (p_vector_lane) else $error("Vector not on CPU lane zero.");

   property p_no_vector_kept;
      $rose(transfer_ack_n) |-> cpu_data == CPU_DATA_ZERO;
   endproperty
   a_no_vector_kept: assert property (p_no_vector_kept) else $error("Vector still driven after read.");

   property p_ack_one_cycle;
      !transfer_ack_n |=> transfer_ack_n;
   endproperty
   a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("Transfer acknowledge longer than one cycle.");

endmodule

// File: test_cpu_interrupt_path_and_iack.sv
`timescale 1ns/10ps
module test_cpu_interrupt_path_and_iack;
   import intack_pkg::*;

   // ************************************************************
   // Stimulus and observed signals
   // ************************************************************
   logic                  i_core_clk = 1'b0;
   logic                  i_reset_n  = 1'b0;
   logic                  legacy     = 1'b0;
   logic                  err_clear  = 1'b0;
   logic                  enable_set = 1'b0;
   logic                  exc_prefix = 1'b0;
   logic                  irq        = 1'b0;
   logic [BYTE_W-1:0]     vector     = 8'h00;
   logic                  error_src  = 1'b0;
   logic                  err_flag;
   logic                  master_abort;
   logic                  enable_bit;
   logic [CPU_ADDR_W-1:0] branch_addr;
   logic [BYTE_W-1:0]     vector_seen;
   logic                  vector_valid;
   logic                  busy;
   logic                  int_taken;
   int                    bad_count = 0;
   int                    cmp_count = 0;

   always #20 i_core_clk = ~i_core_clk;

   intack_if link_if ();

   intack_bridge intack_bridge_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link_if),
      .i_legacy_err_mode(legacy), .i_err_clear(err_clear), .o_err_flag(err_flag),
      .o_intack_busy(busy), .o_master_abort(master_abort));

   intack_partner intack_partner_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link_if),
      .i_enable_set(enable_set), .i_exc_prefix(exc_prefix), .i_irq(irq), .i_vector(vector),
      .i_error_src(error_src), .o_enable_bit(enable_bit), .o_branch_addr(branch_addr), .o_int_taken(int_taken),
      .o_vector(vector_seen), .o_vector_valid(vector_valid));

   intack_properties intack_properties_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .int_req(link_if.int_req), .nmi_req(link_if.nmi_req), .int_cpu_n(link_if.int_cpu_n),
      .ts_n(link_if.ts_n), .cpu_rd(link_if.cpu_rd), .cpu_addr(link_if.cpu_addr),
      .cpu_tsiz(link_if.cpu_tsiz), .cpu_data(link_if.cpu_data), .transfer_ack_n(link_if.transfer_ack_n),
      .req_n(link_if.req_n), .frame_n(link_if.frame_n), .irdy_n(link_if.irdy_n),
      .cbe_n(link_if.cbe_n), .ad(link_if.ad));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask

   task automatic end_sim();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Error indication with and without the legacy mode, then cleared.
   task automatic run_nmi();
      error_src <= 1'b1;
      tick(8);
      check(err_flag, 1'b1);
      check(link_if.int_cpu_n, 1'b1);
      check(link_if.int_req, 1'b0);
      legacy <= 1'b1;
      tick(3);
      check(link_if.int_cpu_n, 1'b0);
      error_src <= 1'b0;
      err_clear <= 1'b1;
      tick(2);
      check(err_flag, 1'b1);
      tick(6);
      err_clear <= 1'b0;
      tick(3);
      check(err_flag, 1'b0);
      check(link_if.int_cpu_n, 1'b1);
      legacy <= 1'b0;
      tick(1);
   endtask

   // A request is held as long as the CPU has interrupts disabled.
   task automatic run_pending();
      irq <= 1'b1;
      tick(1);
      irq <= 1'b0;
      tick(4);
      check(link_if.int_req, 1'b1);
      check(link_if.int_cpu_n, 1'b0);
      tick(20);
      check(enable_bit, 1'b0);
      check(link_if.int_cpu_n, 1'b0);
   endtask

   // Full acknowledge cycle; the wire is watched at every falling edge.
   task automatic run_ack(input logic [BYTE_W-1:0] vec, input logic prefix);
      logic [CBE_W-1:0]      cmd;
      logic [CBE_W-1:0]      lanes;
      logic [PCI_AD_W-1:0]   addr;
      logic [CPU_DATA_W-1:0] rdata;
      logic                  done;
      logic                  taken;
      cmd   = CBE_IDLE;
      lanes = CBE_IDLE;
      addr  = '0;
      rdata = '0;
      done  = 1'b0;
      taken = 1'b0;
      vector     <= vec;
      exc_prefix <= prefix;
      irq        <= 1'b1;
      tick(1);
      irq        <= 1'b0;
      enable_set <= 1'b1;
      tick(1);
      enable_set <= 1'b0;
      for (int i = 0; i < 60 && !done; i++) begin
         @(negedge i_core_clk);
         if (int_taken === 1'b1) begin
            taken = 1'b1;
         end
         if (!link_if.frame_n) begin
            cmd  = link_if.cbe_n;
            addr = link_if.ad;
         end
         if (!link_if.irdy_n) begin
            lanes = link_if.cbe_n;
         end
         if (!link_if.transfer_ack_n) begin
            rdata = link_if.cpu_data;
            check(busy, 1'b1);
         end
         if (vector_valid === 1'b1) begin
            done = 1'b1;
            check(link_if.cpu_data, CPU_DATA_ZERO);
         end
      end
      check(done, 1'b1);
      check(busy, 1'b0);
      check(taken, 1'b1);
      check(cmd, PCI_CMD_INTACK);
      check(addr, INTACK_ADDR);
      check(lanes, CBE_LANE0_ONLY);
      check(rdata, {vec, 56'h0});
      check(vector_seen, vec);
      check(link_if.int_req, 1'b0);
      check(enable_bit, 1'b0);
      check(branch_addr, prefix ? VECTOR_LOC_HIGH : VECTOR_LOC_LOW);
      check(master_abort, 1'b0);
      tick(3);
      check(link_if.int_cpu_n, 1'b1);
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial begin
      tick(10);
      i_reset_n <= 1'b1;
      tick(2);
      run_nmi();
      run_pending();
      run_ack(8'h00, 1'b0);
      run_ack(8'hff, 1'b1);
      run_ack(8'ha5, 1'b0);
      end_sim();
   end

   // The whole run needs about a hundred cycles; this bound leaves ample margin.
   initial begin
      tick(5000);
      bad_count++;
      end_sim();
   end

endmodule
